// *** node_cfg_map.vh ***
// constants for node strap configuration, register map and indicator timing
`ifndef NODE_CFG_MAP_VH
`define NODE_CFG_MAP_VH
`define CLK_HZ 25000000
`define FLASH_ON_MS 200
`define BLINK_MS 200
`define SELFTEST_MS 500
`define FLASH_ON_CYC ((`CLK_HZ / 1000) * `FLASH_ON_MS)
`define BLINK_CYC ((`CLK_HZ / 1000) * `BLINK_MS)
`define SELFTEST_CYC ((`CLK_HZ / 1000) * `SELFTEST_MS)
`define OFF_STATUS 4'h0
`define OFF_BAUD_OBJ 4'h1
`define OFF_NODE_OBJ 4'h2
`define OFF_CONTROL 4'h3
`define OFF_NET_STATE 4'h4
`define OFF_ERR_FLAGS 4'h5
`define OFF_HW_CPR 4'h6
`define OFF_HW_TURNS 4'h7
`define OFF_PHYS_CPR 4'h8
`define OFF_PHYS_TURNS 4'h9
`define BAUD_DEFAULT 3'h5
`define NODE_DEFAULT 7'h01
`define NODE_MAX 7'h7F
`define ST_PREOP 2'h0
`define ST_OPER 2'h1
`define ST_STOP 2'h2
`define CTL_RESET_NODE 0
`define ERR_BUS_OFF 0
`define ERR_GUARD 1
`define ERR_WARN 2
`define ERR_GENERIC 3
`define ERR_FLASH 4
`define UNMAPPED_DATA 32'h00000000
`define OFF_STORE 4'hA
`define STORE_SIG 32'h65766173
`define STORE_ACK 8'h60
`endif

// *** led_pattern_gen.v ***
// indicator pattern generator: on, off, blink, single and double flash
`timescale 1ns/1ns
`default_nettype none
module led_pattern_gen #(
  parameter TICK_CYC = 5000000
) (
  input wire mclk, // system clock
  input wire sys_rst, // async reset, active high
  output reg [1:0] pat_reg // bit0 blink phase, bit1 flash slot (high in slot 0 of the 8, see below)
);
  // a tick every TICK_CYC cycles; an 8-slot frame gives the flash sequences
  reg [31:0] cnt_reg;
  reg [2:0] slot_reg;
  wire tick = (cnt_reg == TICK_CYC - 1);
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 32'h00000000;
      slot_reg <= 3'h0;
      pat_reg <= 2'h0;
    end
    else
    begin
      cnt_reg <= tick ? 32'h00000000 : cnt_reg + 32'h00000001;
      if (tick)
        slot_reg <= slot_reg + 3'h1;
      // bit0: blink (alternate each tick); bit1: single flash slot 0, double uses slots 0 and 2
      pat_reg[0] <= slot_reg[0];
      pat_reg[1] <= (slot_reg == 3'h0);
    end
  end
endmodule
`default_nettype wire

// *** node_strap_config.v ***
// node strap configuration loader with run and error indicator drive
// What this block does
// - baud switch four on selects switch rate, off selects software baud object.
// - baud switches one to three form binary code, switch one least significant.
// - code maps 0..7 to 20,50,100,125,250,500,800,1000 kbit/s; default 5.
// - all address switches off means node id comes from software object.
// - any of address switches one to seven on makes the switch value the node id.
// - node ids accepted only from 1 to 127; default is 1.
// - address switches one to seven are binary weights, switch eight ignored.
// - green led on when operational, single flash stopped, blinking pre-operational.
// - red led on bus-off, double flash guard, single flash warning, blink error.
// - at initialization both leds light together as a self-test.
// - scaling valid only when hardware counts and turns match the sensor.
// - store needs signature 73 61 76 65 on sub-index 01; answer 60.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "node_cfg_map.vh"
module node_strap_config #(
  parameter FLASH_CYC = `FLASH_ON_CYC,
  parameter SELFTEST_CYC = `SELFTEST_CYC,
  parameter [31:0] PHYS_CPR = 32'h00001000,
  parameter [31:0] PHYS_TURNS = 32'h00000001
) (
  input wire mclk, // 25 MHz system clock
  input wire sys_rst, // async reset, active high
  input wire [3:0] baud_switch_bank, // bit0 = switch one, bit3 = hw/sw select
  input wire [7:0] node_address_switch_bank, // bit0 = switch one, bit7 unused
  input wire reset_node, // one-cycle pulse from network layer on reset-node command
  input wire [1:0] net_state, // network state from the state machine
  input wire [4:0] err_in, // error levels: bus-off, guard, warn, generic, flash
  input wire [3:0] avs_address, // word address
  input wire avs_read, // read strobe
  input wire avs_write, // write strobe
  input wire [31:0] avs_writedata, // write data
  input wire [3:0] avs_byteenable, // byte enables
  output reg [31:0] avs_readdata, // read data
  output wire avs_waitrequest, // stall until answer ready
  output reg [2:0] baud_code, // active bit rate code
  output reg [9:0] baud_kbps, // active bit rate in kbit/s
  output reg [6:0] node_id, // active node identifier
  output wire scaling_valid, // hardware resolution matches sensor
  output reg run_led, // green run led, active high
  output reg err_led // red error led, active high
);
  function [9:0] baud_to_kbps;
    input [2:0] code;
    begin
      case (code)
        3'h0: baud_to_kbps = 10'h014;
        3'h1: baud_to_kbps = 10'h032;
        3'h2: baud_to_kbps = 10'h064;
        3'h3: baud_to_kbps = 10'h07D;
        3'h4: baud_to_kbps = 10'h0FA;
        3'h5: baud_to_kbps = 10'h1F4;
        3'h6: baud_to_kbps = 10'h320;
        default: baud_to_kbps = 10'h3E8;
      endcase
    end
  endfunction
  function [7:0] merge8;
    input [7:0] old;
    input [7:0] nw;
    input be;
    begin
      merge8 = be ? nw : old;
    end
  endfunction

  localparam S_IDLE = 1'b0;
  localparam S_ACK = 1'b1;

  reg [3:0] baud_sw_reg;
  reg [6:0] addr_sw_reg;
  reg strap_done_reg;
  reg [2:0] baud_obj_reg;
  reg [6:0] node_obj_reg;
  reg [31:0] hw_cpr_reg;
  reg [31:0] hw_turns_reg;
  reg bus_state_reg;
  reg [31:0] selftest_cnt_reg;
  reg selftest_reg;
  wire [1:0] pat;
  wire rd_hit;
  reg [31:0] rd_next;
  // acknowledge of the last store request; it only reports the signature check,
  // keeping the objects in non-volatile memory is left to the firmware
  reg store_ok_reg;

  // straps latched on the first clock after reset release, never again
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      baud_sw_reg <= 4'h0;
      addr_sw_reg <= 7'h00;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      baud_sw_reg <= baud_switch_bank;
      addr_sw_reg <= node_address_switch_bank[6:0];
      strap_done_reg <= 1'b1;
    end
  end

  // software objects, written over the bus; out-of-range ids are refused
  // a write lands on the edge where the master sees waitrequest low, as a read hands over its data there
  wire wr = avs_write && bus_state_reg == S_ACK;
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      baud_obj_reg <= `BAUD_DEFAULT;
      node_obj_reg <= `NODE_DEFAULT;
      hw_cpr_reg <= 32'h00001000;
      hw_turns_reg <= 32'h00000001;
      store_ok_reg <= 1'b0;
    end
    else if (wr)
    begin
      case (avs_address)
        `OFF_BAUD_OBJ:
          if (avs_byteenable[0])
            baud_obj_reg <= avs_writedata[2:0];
        `OFF_NODE_OBJ:
          if (avs_byteenable[0] && avs_writedata[6:0] != 7'h00)
            node_obj_reg <= avs_writedata[6:0];
        `OFF_HW_CPR:
          hw_cpr_reg <= {merge8(hw_cpr_reg[31:24], avs_writedata[31:24], avs_byteenable[3]),
                         merge8(hw_cpr_reg[23:16], avs_writedata[23:16], avs_byteenable[2]),
                         merge8(hw_cpr_reg[15:8], avs_writedata[15:8], avs_byteenable[1]),
                         merge8(hw_cpr_reg[7:0], avs_writedata[7:0], avs_byteenable[0])};
        `OFF_HW_TURNS:
          hw_turns_reg <= {merge8(hw_turns_reg[31:24], avs_writedata[31:24], avs_byteenable[3]),
                           merge8(hw_turns_reg[23:16], avs_writedata[23:16], avs_byteenable[2]),
                           merge8(hw_turns_reg[15:8], avs_writedata[15:8], avs_byteenable[1]),
                           merge8(hw_turns_reg[7:0], avs_writedata[7:0], avs_byteenable[0])};
        `OFF_STORE:
          // any other word, or a partial write, withdraws the acknowledge
          store_ok_reg <= (avs_byteenable == 4'hF) && (avs_writedata == `STORE_SIG);
        default:
          ;
      endcase
    end
  end

  // scaling only trusted when the configured resolution matches the sensor
  assign scaling_valid = (hw_cpr_reg == PHYS_CPR) && (hw_turns_reg == PHYS_TURNS);

  // active configuration: loaded once after straps, refreshed only on reset-node
  reg load_pend_reg;
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      baud_code <= `BAUD_DEFAULT;
      baud_kbps <= 10'h1F4;
      node_id <= `NODE_DEFAULT;
      load_pend_reg <= 1'b1;
    end
    else if (strap_done_reg && (load_pend_reg || reset_node))
    begin
      load_pend_reg <= 1'b0;
      if (baud_sw_reg[3])
      begin
        baud_code <= baud_sw_reg[2:0];
        baud_kbps <= baud_to_kbps(baud_sw_reg[2:0]);
      end
      else
      begin
        baud_code <= baud_obj_reg;
        baud_kbps <= baud_to_kbps(baud_obj_reg);
      end
      if (addr_sw_reg != 7'h00)
        node_id <= addr_sw_reg;
      else
        node_id <= node_obj_reg;
    end
  end

  // indicator self-test after reset, then normal patterns
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      selftest_cnt_reg <= 32'h00000000;
      selftest_reg <= 1'b1;
    end
    else if (selftest_reg)
    begin
      selftest_cnt_reg <= selftest_cnt_reg + 32'h00000001;
      if (selftest_cnt_reg == SELFTEST_CYC - 1)
        selftest_reg <= 1'b0;
    end
  end

  led_pattern_gen #(
    .TICK_CYC(FLASH_CYC)
  ) u_pat (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pat_reg(pat)
  );

  // double flash is slot 0 or slot 2 of the 8-slot frame
  reg [2:0] slot_d_reg;
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      slot_d_reg <= 3'h0;
    else if (pat[1])
      slot_d_reg <= 3'h0;
    else if (pat[0] != slot_d_reg[0])
      slot_d_reg <= slot_d_reg + 3'h1;
  end
  wire single_fl = pat[1] && pat[0] == 1'b0;
  // slot_d_reg trails the pattern by one cycle, so slot 2 opens while it still reads 1;
  // both values count, otherwise the second flash loses its first cycle
  wire second_fl = !pat[0] && (slot_d_reg == 3'h1 || slot_d_reg == 3'h2);
  wire double_fl = single_fl || second_fl;

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      run_led <= 1'b0;
      err_led <= 1'b0;
    end
    else if (selftest_reg)
    begin
      run_led <= 1'b1;
      err_led <= 1'b1;
    end
    else
    begin
      case (net_state)
        `ST_OPER: run_led <= 1'b1;
        `ST_STOP: run_led <= single_fl;
        default: run_led <= pat[0];
      endcase
      // bus-off outranks guarding, which outranks warning and generic faults
      if (err_in[`ERR_BUS_OFF])
        err_led <= 1'b1;
      else if (err_in[`ERR_GUARD])
        err_led <= double_fl;
      else if (err_in[`ERR_WARN])
        err_led <= single_fl;
      else if (err_in[`ERR_GENERIC] || err_in[`ERR_FLASH])
        err_led <= pat[0];
      else
        err_led <= 1'b0;
    end
  end

  // avalon slave: waitrequest high in the first cycle of a request, low in the second;
  // read data are registered in the first cycle so they stand when the master takes them
  assign rd_hit = avs_read && bus_state_reg == S_IDLE;
  assign avs_waitrequest = (avs_read || avs_write) && bus_state_reg == S_IDLE;
  always @*
  begin
    case (avs_address)
      `OFF_STATUS: rd_next = {19'h00000, scaling_valid, selftest_reg, strap_done_reg, node_id, baud_code};
      `OFF_BAUD_OBJ: rd_next = {29'h00000000, baud_obj_reg};
      `OFF_NODE_OBJ: rd_next = {25'h0000000, node_obj_reg};
      `OFF_CONTROL: rd_next = {20'h00000, addr_sw_reg, 1'b0, baud_sw_reg};
      `OFF_NET_STATE: rd_next = {30'h00000000, net_state};
      `OFF_ERR_FLAGS: rd_next = {27'h0000000, err_in};
      `OFF_HW_CPR: rd_next = hw_cpr_reg;
      `OFF_HW_TURNS: rd_next = hw_turns_reg;
      `OFF_PHYS_CPR: rd_next = PHYS_CPR;
      `OFF_PHYS_TURNS: rd_next = PHYS_TURNS;
      `OFF_STORE: rd_next = {24'h000000, store_ok_reg ? `STORE_ACK : 8'h00};
      default: rd_next = `UNMAPPED_DATA;
    endcase
  end
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_state_reg <= S_IDLE;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      case (bus_state_reg)
        S_IDLE:
          if (avs_read || avs_write)
            bus_state_reg <= S_ACK;
        default:
          bus_state_reg <= S_IDLE;
      endcase
      if (rd_hit)
        avs_readdata <= rd_next;
    end
  end
endmodule
`default_nettype wire

// *** node_strap_checker.sv ***
// assertion checker for the node strap configuration block
`timescale 1ns/1ns
`default_nettype none
module node_strap_checker (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic [3:0] baud_switch_bank, // baud straps
  input wire logic [7:0] node_address_switch_bank, // address straps
  input wire logic reset_node, // reload pulse
  input wire logic [1:0] net_state, // network state
  input wire logic [4:0] err_in, // error levels
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic avs_waitrequest, // stall
  input wire logic [2:0] baud_code, // bit rate code
  input wire logic [9:0] baud_kbps, // bit rate
  input wire logic [6:0] node_id, // node id
  input wire logic run_led, // green led
  input wire logic err_led // red led
);
  localparam logic [79:0] KT = {10'h3E8, 10'h320, 10'h1F4, 10'h0FA, 10'h07D, 10'h064, 10'h032, 10'h014};
  logic [4:0] up;
  logic [3:0] sb;
  logic [7:0] sn;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // straps captured on the edge the design latches them, so later switch moves are ignored here too
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      up <= 5'h00;
      sb <= 4'h0;
      sn <= 8'h00;
    end
    else
    begin
      if (up != 5'h1F)
        up <= up + 5'h01;
      if (up == 5'h00)
      begin
        sb <= baud_switch_bank;
        sn <= node_address_switch_bank;
      end
    end
  end
  AST_KBPS: assert property (up > 5'h02 |-> baud_kbps == KT[10*baud_code +: 10])
    else $error("bit rate does not match its code");
  AST_NODE_RANGE: assert property (up > 5'h02 |-> node_id != 7'h00)
    else $error("node id out of range");
  AST_HW_BAUD: assert property (up > 5'h02 && sb[3] |-> baud_code == sb[2:0])
    else $error("bit rate not taken from switches");
  AST_HW_NODE: assert property (up > 5'h02 && sn[6:0] != 7'h00 |-> node_id == sn[6:0])
    else $error("node id not taken from switches");
  AST_HOLD: assert property (up > 5'h03 && !$past(reset_node) |-> $stable(baud_code) && $stable(node_id))
    else $error("configuration changed without reload");
  AST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing wrong");
  AST_SELFTEST: assert property (up == 5'h01 |-> (run_led && err_led) [*8])
    else $error("indicator self test missing");
  AST_BUSOFF: assert property (up == 5'h1F && err_in[0] && $past(err_in[0]) && $past(err_in[0], 2) |-> err_led)
    else $error("red led not steady at bus off");
  AST_NO_ERR: assert property (up == 5'h1F && err_in == 5'h00 && $past(err_in) == 5'h00 |=> !err_led)
    else $error("red led lit without error");
  AST_RUN_ON: assert property (up == 5'h1F && net_state == 2'h1 && $past(net_state) == 2'h1 |=> run_led)
    else $error("green led not steady when operational");
  cover property (reset_node);
  cover property (up == 5'h1F && err_in[1] && err_led);
  cover property (avs_write && !avs_waitrequest);
endmodule
`default_nettype wire

// *** can_master_model.sv ***
// network master model: node state, error levels and reset-node events
`timescale 1ns/1ns
`default_nettype none
module can_master_model (
  input wire logic mclk, // system clock
  output logic reset_node, // reload pulse
  output logic [1:0] net_state, // network state
  output logic [4:0] err_in // error levels
);
  // bit rate is assumed known; rate scanning belongs to system tests
  initial
  begin
    reset_node = 1'b0;
    net_state = 2'h0;
    err_in = 5'h00;
  end
  task send_reset_node();
    @(posedge mclk);
    reset_node <= 1'b1;
    @(posedge mclk);
    reset_node <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task set_status(input logic [1:0] s, input logic [4:0] e);
    @(posedge mclk);
    net_state <= s;
    err_in <= e;
  endtask
endmodule
`default_nettype wire

// *** tb_node_strap_config.sv ***
// self-checking bench for the node strap configuration block
`timescale 1ns/1ns
`default_nettype none
module tb_node_strap_config;
  localparam logic [79:0] KT = {10'h3E8, 10'h320, 10'h1F4, 10'h0FA, 10'h07D, 10'h064, 10'h032, 10'h014};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] baud_sw = 4'hC;
  logic [7:0] node_sw = 8'h99;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, ons;
  logic avs_waitrequest, scaling_valid, run_led, err_led, reset_node;
  logic [2:0] baud_code;
  logic [9:0] baud_kbps;
  logic [6:0] node_id;
  logic [1:0] net_state;
  logic [4:0] err_in;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  always #20 mclk = ~mclk;
  can_master_model pm (.mclk(mclk), .reset_node(reset_node), .net_state(net_state), .err_in(err_in));
  node_strap_config #(.FLASH_CYC(4), .SELFTEST_CYC(10)) uut (.mclk(mclk), .sys_rst(sys_rst),
    .baud_switch_bank(baud_sw), .node_address_switch_bank(node_sw), .reset_node(reset_node),
    .net_state(net_state), .err_in(err_in), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .baud_code(baud_code), .baud_kbps(baud_kbps), .node_id(node_id),
    .scaling_valid(scaling_valid), .run_led(run_led), .err_led(err_led));
  task end_of_test();
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task bus(input logic rw, input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !rw;
    avs_write <= rw;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    if (!rw)
      chk(avs_readdata, exp);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task do_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({run_led, err_led}, 32'h3);
  endtask
  task expect_cfg(input logic [2:0] c, input logic [6:0] n);
    chk(baud_code, c);
    chk(baud_kbps, KT[10*c +: 10]);
    chk(node_id, n);
  endtask
  // whole frames only, so the count does not depend on the pattern phase
  task count_led(input logic [1:0] s, input logic [4:0] e, input logic red, input logic [31:0] exp);
    pm.set_status(s, e);
    repeat (8) @(posedge mclk);
    ons = 32'h0;
    repeat (64)
    begin
      @(posedge mclk);
      ons = ons + (red ? err_led : run_led);
    end
    chk(ons, exp);
  endtask
  initial
  begin
    for (int c = 0; c < 8; c++)
    begin
      baud_sw <= {1'b1, c[2:0]};
      do_reset();
      expect_cfg(c[2:0], 7'h19);
    end
    baud_sw <= 4'h9;
    node_sw <= 8'h37;
    pm.send_reset_node();
    expect_cfg(3'h7, 7'h19);
    baud_sw <= 4'h7;
    node_sw <= 8'h80;
    do_reset();
    expect_cfg(3'h5, 7'h01);
    bus(1'b0, 4'h1, 32'h0, 32'h5);
    bus(1'b0, 4'h2, 32'h0, 32'h1);
    bus(1'b1, 4'h1, 32'h2, 32'h0);
    bus(1'b1, 4'h2, 32'h0, 32'h0);
    bus(1'b0, 4'h2, 32'h0, 32'h1);
    bus(1'b1, 4'h2, 32'h37, 32'h0);
    expect_cfg(3'h5, 7'h01);
    pm.send_reset_node();
    expect_cfg(3'h2, 7'h37);
    bus(1'b1, 4'hA, 32'h65766173, 32'h0);
    bus(1'b0, 4'hA, 32'h0, 32'h60);
    bus(1'b1, 4'hA, 32'h65766174, 32'h0);
    bus(1'b0, 4'hA, 32'h0, 32'h0);
    bus(1'b0, 4'hF, 32'h0, 32'h0);
    chk(scaling_valid, 32'h1);
    bus(1'b1, 4'h6, 32'h2000, 32'h0);
    // the write lands on the edge that ends the access, so look one edge later
    @(posedge mclk);
    chk(scaling_valid, 32'h0);
    count_led(2'h1, 5'h00, 1'b0, 32'h40);
    count_led(2'h2, 5'h00, 1'b0, 32'h08);
    count_led(2'h0, 5'h00, 1'b0, 32'h20);
    count_led(2'h1, 5'h03, 1'b1, 32'h40);
    count_led(2'h1, 5'h02, 1'b1, 32'h10);
    count_led(2'h1, 5'h04, 1'b1, 32'h08);
    count_led(2'h1, 5'h08, 1'b1, 32'h20);
    count_led(2'h1, 5'h10, 1'b1, 32'h20);
    count_led(2'h1, 5'h00, 1'b1, 32'h00);
    end_of_test();
  end
endmodule
bind node_strap_config node_strap_checker chk_i (.mclk, .sys_rst, .baud_switch_bank, .node_address_switch_bank,
  .reset_node, .net_state, .err_in, .avs_read, .avs_write, .avs_waitrequest, .baud_code, .baud_kbps, .node_id,
  .run_led, .err_led);
`default_nettype wire
